// [verilog/dcp_pkg.sv]
// Package: register map, field layout, codes and helpers for the arm/priority block
package dcp_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NCH = 5;
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;
  localparam int DAT_W = 32;
  localparam int CFG_W = 9;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_ARM = 10'h0D6;
  localparam logic [9:0] IDX_STAT = 10'h0D1;
  localparam logic [9:0] IDX_CFG0 = 10'h0E0;
  localparam logic [9:0] IDX_MASK = 10'h0E8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ARM_ABORT_BIT = 7;
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_M8_BIT = 2;
  localparam int CFG_IRQEN_BIT = 3;
  localparam int CFG_WORD_BIT = 4;
  localparam int CFG_VARIABLE_LENGTH_SELECT_LSB = 5;
  localparam int CFG_REP_BIT = 8;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [4:0] ARM_RST = 5'h00;
  localparam logic [4:0] FLAG_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [8:0] CFG_RST = 9'h000;
  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_NORMAL = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;
  localparam logic [1:0] PRIO_RSVD = 2'h3;
  localparam logic [2:0] VARIABLE_LENGTH_SELECT_FIXED_A = 3'h0;
  localparam logic [2:0] VARIABLE_LENGTH_SELECT_FIXED_B = 3'h7;

  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } dcp_wb_e;

  // One-hot channel decode; numbers above the last channel give zero
  function automatic logic [4:0] dcp_chan_bit(input logic [2:0] ch);
    logic [4:0] v;
    v = 5'h00;
    if (ch < 3'h5) begin
      v[ch] = 1'b1;
    end
    return v;
  endfunction : dcp_chan_bit
endpackage : dcp_pkg

// [verilog/dcp_bus_arbiter.sv]
// CPU versus DMA memory access arbiter with per-channel priority code
`timescale 1ns/1ns
module dcp_bus_arbiter (
  input wire logic mclk,
  input wire logic rstSync,
  input wire logic ce,
  input wire logic cpuReq,
  input wire logic dmaReq,
  input wire logic [1:0] prio,
  output logic cpuGnt,
  output logic dmaGnt
);
  logic owed;
  logic next_owed;
  logic next_cpuGnt;
  logic next_dmaGnt;
  logic conflict;
  logic fairMode;

  // ----------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------
  assign conflict = cpuReq && dmaReq;
  // Reserved code treated as normal so a stray setting cannot starve anyone
  assign fairMode = (prio == dcp_pkg::PRIO_NORMAL) || (prio == dcp_pkg::PRIO_RSVD);

  always_comb begin
    next_owed = owed;
    next_cpuGnt = cpuReq && !dmaReq;
    next_dmaGnt = dmaReq && !cpuReq;
    if (conflict) begin
      if (prio == dcp_pkg::PRIO_LOW) begin
        next_cpuGnt = 1'b1;
      end else if (prio == dcp_pkg::PRIO_HIGH) begin
        next_dmaGnt = 1'b1;
      end else begin
        next_dmaGnt = owed;
        next_cpuGnt = !owed;
        next_owed = !owed;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      owed <= 1'b0;
      cpuGnt <= 1'b0;
      dmaGnt <= 1'b0;
    end else if (ce) begin
      owed <= next_owed;
      cpuGnt <= next_cpuGnt;
      dmaGnt <= next_dmaGnt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_low_cpu_first: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && conflict && prio == dcp_pkg::PRIO_LOW |=> cpuGnt && !dmaGnt)
    else $error("low priority dma took the bus from the cpu");
  chk_normal_fair_share: assert property (@(posedge mclk) disable iff (!rstSync)
    (ce && conflict && fairMode) ##1 (cpuGnt && ce && conflict && fairMode) |=> dmaGnt && !cpuGnt)
    else $error("normal priority dma lost twice in a row");
  chk_high_dma_first: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && conflict && prio == dcp_pkg::PRIO_HIGH |=> dmaGnt && !cpuGnt)
    else $error("high priority dma deferred to the cpu");
  chk_grant_needs_req: assert property (@(posedge mclk) disable iff (!rstSync)
    dmaGnt && $past(ce) |-> $past(dmaReq))
    else $error("dma grant without an armed request");
endmodule : dcp_bus_arbiter

// [verilog/dcp_len_decode.sv]
// Variable transfer count taken from the first source byte
`timescale 1ns/1ns
module dcp_len_decode (
  input wire logic mclk,
  input wire logic rstSync,
  input wire logic ce,
  input wire logic firstValid,
  input wire logic [7:0] firstByte,
  input wire logic [2:0] variable_length_select,
  input wire logic m8,
  input wire logic wordWidth,
  output logic [7:0] xferCount,
  output logic countValid
);
  logic varLen;
  logic sevenBit;
  logic [7:0] next_xferCount;
  logic next_countValid;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign varLen = (variable_length_select != dcp_pkg::VARIABLE_LENGTH_SELECT_FIXED_A) && (variable_length_select != dcp_pkg::VARIABLE_LENGTH_SELECT_FIXED_B);
  assign sevenBit = m8 && !wordWidth;

  always_comb begin
    next_xferCount = xferCount;
    next_countValid = 1'b0;
    if (firstValid && varLen) begin
      next_countValid = 1'b1;
      next_xferCount = sevenBit ? {1'b0, firstByte[6:0]} : firstByte;
    end
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      xferCount <= 8'h00;
      countValid <= 1'b0;
    end else if (ce) begin
      xferCount <= next_xferCount;
      countValid <= next_countValid;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_seven_bit_count: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && firstValid && varLen && m8 && !wordWidth |=> countValid && xferCount == {1'b0, $past(firstByte[6:0])})
    else $error("seven bit count not taken from low bits");
  chk_word_full_count: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && firstValid && varLen && wordWidth |=> countValid && xferCount == $past(firstByte))
    else $error("word transfer count was truncated");
endmodule : dcp_len_decode

// [verilog/dcp_arm_ctrl.sv]
// Channel arm, abort, per-channel config, done flags and arbitration top
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
module dcp_arm_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpuReq,
  input wire logic dmaReq,
  input wire logic [2:0] dmaChan,
  input wire logic cntDone,
  input wire logic [2:0] cntChan,
  input wire logic firstValid,
  input wire logic [2:0] firstChan,
  input wire logic [7:0] firstByte,
  output logic cpuGnt,
  output logic dmaGnt,
  output logic [4:0] chArmed,
  output logic [4:0] chAbort,
  output logic [7:0] xferCount,
  output logic countValid,
  output logic irq
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dcp_pkg::dcp_wb_e state;
  dcp_pkg::dcp_wb_e next_state;
  logic [8:0] cfg [dcp_pkg::NCH];
  logic [8:0] next_cfg [dcp_pkg::NCH];
  logic [4:0] flags;
  logic [4:0] next_flags;
  logic [4:0] mask;
  logic [4:0] next_mask;
  logic [4:0] next_armed;
  logic [4:0] next_abort;
  logic [31:0] next_rdat;
  logic next_ack;
  logic next_irq;
  logic [4:0] irqEnVec;
  logic [4:0] next_irqEn;
  logic [4:0] doneVec;
  logic [9:0] adrIdx;
  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic cfgHit;
  logic [2:0] cfgSel;
  logic dmaOk;
  logic [1:0] activePrio;
  logic [8:0] firstCfg;
  logic firstOk;

  // Armed test; channel numbers past the last one never match
  function automatic logic dcp_chan_armed(input logic [2:0] ch, input logic [4:0] arm);
    return |(dcp_pkg::dcp_chan_bit(ch) & arm);
  endfunction : dcp_chan_armed

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign adrIdx = wb_adr_i[11:2];
  assign acc = (state == dcp_pkg::WB_IDLE) && wb_cyc_i && wb_stb_i;
  assign wrAcc = acc && wb_we_i && wb_sel_i[0];
  assign rdAcc = acc && !wb_we_i;
  assign cfgHit = (adrIdx >= dcp_pkg::IDX_CFG0) && (adrIdx < dcp_pkg::IDX_CFG0 + 10'h005);
  assign cfgSel = 3'(adrIdx - dcp_pkg::IDX_CFG0);
  // Done events on a disarmed channel are ignored
  assign doneVec = cntDone ? (dcp_pkg::dcp_chan_bit(cntChan) & chArmed) : 5'h00;
  assign dmaOk = dmaReq && dcp_chan_armed(dmaChan, chArmed);
  assign firstOk = firstValid && dcp_chan_armed(firstChan, chArmed);
  assign activePrio = (dmaChan < 3'h5) ? cfg[dmaChan][1:0] : dcp_pkg::PRIO_LOW;
  assign firstCfg = (firstChan < 3'h5) ? cfg[firstChan] : dcp_pkg::CFG_RST;

  always_comb begin
    for (int i = 0; i < dcp_pkg::NCH; i++) begin
      irqEnVec[i] = cfg[i][dcp_pkg::CFG_IRQEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ack = 1'b0;
    next_rdat = 32'h0000_0000;
    next_armed = chArmed;
    next_abort = 5'h00;
    next_flags = flags;
    next_mask = mask;
    next_cfg = cfg;
    for (int i = 0; i < dcp_pkg::NCH; i++) begin
      if (doneVec[i] && !cfg[i][dcp_pkg::CFG_REP_BIT]) begin
        next_armed[i] = 1'b0;
      end
    end
    case (state)
      dcp_pkg::WB_IDLE: begin
        if (acc) begin
          next_state = dcp_pkg::WB_ACK;
          next_ack = 1'b1;
          if (rdAcc) begin
            if (adrIdx == dcp_pkg::IDX_ARM) begin
              next_rdat = {27'h0, chArmed};
            end else if (adrIdx == dcp_pkg::IDX_STAT) begin
              next_rdat = {27'h0, flags};
              next_flags = 5'h00;
            end else if (adrIdx == dcp_pkg::IDX_MASK) begin
              next_rdat = {27'h0, mask};
            end else if (cfgHit) begin
              next_rdat = {23'h0, cfg[cfgSel]};
            end
          end
          if (wrAcc) begin
            if (adrIdx == dcp_pkg::IDX_ARM) begin
              if (wb_dat_i[dcp_pkg::ARM_ABORT_BIT]) begin
                next_armed = next_armed & ~wb_dat_i[4:0];
                next_abort = wb_dat_i[4:0];
              end else begin
                next_armed = wb_dat_i[4:0];
              end
            end else if (adrIdx == dcp_pkg::IDX_STAT) begin
              next_flags = next_flags & wb_dat_i[4:0];
            end else if (adrIdx == dcp_pkg::IDX_MASK) begin
              next_mask = wb_dat_i[4:0];
            end else if (cfgHit) begin
              next_cfg[cfgSel][7:0] = wb_dat_i[7:0];
              if (wb_sel_i[1]) begin
                next_cfg[cfgSel][8] = wb_dat_i[8];
              end
            end
          end
        end
      end
      dcp_pkg::WB_ACK: begin
        next_state = dcp_pkg::WB_IDLE;
      end
      default: begin
        next_state = dcp_pkg::WB_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle
    next_flags = next_flags | doneVec;
    for (int i = 0; i < dcp_pkg::NCH; i++) begin
      next_irqEn[i] = next_cfg[i][dcp_pkg::CFG_IRQEN_BIT];
    end
    next_irq = |(next_flags & next_mask & next_irqEn);
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      state <= dcp_pkg::WB_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      chArmed <= dcp_pkg::ARM_RST;
      chAbort <= 5'h00;
      flags <= dcp_pkg::FLAG_RST;
      mask <= dcp_pkg::MASK_RST;
      irq <= 1'b0;
      for (int i = 0; i < dcp_pkg::NCH; i++) begin
        cfg[i] <= dcp_pkg::CFG_RST;
      end
    end else if (ce) begin
      state <= next_state;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
      chArmed <= next_armed;
      chAbort <= next_abort;
      flags <= next_flags;
      mask <= next_mask;
      irq <= next_irq;
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Arbiter and count decode
  // ----------------------------------------------------------------
  dcp_bus_arbiter u_arb (
    .mclk(mclk),
    .rstSync(rstSync),
    .ce(ce),
    .cpuReq(cpuReq),
    .dmaReq(dmaOk),
    .prio(activePrio),
    .cpuGnt(cpuGnt),
    .dmaGnt(dmaGnt)
  );

  dcp_len_decode u_len (
    .mclk(mclk),
    .rstSync(rstSync),
    .ce(ce),
    .firstValid(firstOk),
    .firstByte(firstByte),
    .variable_length_select(firstCfg[7:5]),
    .m8(firstCfg[dcp_pkg::CFG_M8_BIT]),
    .wordWidth(firstCfg[dcp_pkg::CFG_WORD_BIT]),
    .xferCount(xferCount),
    .countValid(countValid)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_irq_gate: assert property (@(posedge mclk) disable iff (!rstSync)
    irq == (|(flags & mask & irqEnVec)))
    else $error("interrupt level disagrees with enabled flags");
  chk_abort_disarm: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && wrAcc && adrIdx == dcp_pkg::IDX_ARM && wb_dat_i[7]
    |=> (chArmed & $past(wb_dat_i[4:0])) == 5'h00 && chAbort == $past(wb_dat_i[4:0]))
    else $error("aborted channel still armed");
  chk_abort_reads_zero: assert property (@(posedge mclk) disable iff (!rstSync)
    $past(ce && rdAcc && adrIdx == dcp_pkg::IDX_ARM) |-> wb_ack_o && wb_dat_o[7:5] == 3'h0)
    else $error("abort bit read back as one");
  chk_auto_disarm: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && |doneVec && !(wrAcc && adrIdx == dcp_pkg::IDX_ARM) && !cfg[cntChan][dcp_pkg::CFG_REP_BIT]
    |=> !chArmed[$past(cntChan)])
    else $error("non-repetitive channel stayed armed");
  chk_flag_set: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && |doneVec |=> (flags & $past(doneVec)) == $past(doneVec))
    else $error("done flag not set on count reached");

  // ----------------------------------------------------------------
  // Bus, arm and flag checks
  // ----------------------------------------------------------------
  chk_ack_one_cycle: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held past one cycle");
  chk_ack_needs_request: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && !acc |=> !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("bus acknowledge or data without a request");
  chk_grant_exclusive: assert property (@(posedge mclk) disable iff (!rstSync)
    !(cpuGnt && dmaGnt))
    else $error("cpu and dma granted together");
  chk_arm_write: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && wrAcc && adrIdx == dcp_pkg::IDX_ARM && !wb_dat_i[dcp_pkg::ARM_ABORT_BIT]
    |=> chArmed == $past(wb_dat_i[4:0]))
    else $error("arm write did not land");
  chk_abort_keeps_rest: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && wrAcc && adrIdx == dcp_pkg::IDX_ARM && wb_dat_i[dcp_pkg::ARM_ABORT_BIT] && doneVec == 5'h00
    |=> chArmed == ($past(chArmed) & ~$past(wb_dat_i[4:0])))
    else $error("abort touched unselected channels");
  chk_abort_strobe_only: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && !(wrAcc && adrIdx == dcp_pkg::IDX_ARM && wb_dat_i[dcp_pkg::ARM_ABORT_BIT]) |=> chAbort == 5'h00)
    else $error("abort pulse without an abort write");
  chk_unarmed_no_grant: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && !dcp_chan_armed(dmaChan, chArmed) |=> !dmaGnt)
    else $error("dma grant for a disarmed channel");
  chk_unarmed_no_count: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && !dcp_chan_armed(firstChan, chArmed) |=> !countValid)
    else $error("count taken for a disarmed channel");
  chk_repeat_stays_armed: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && |doneVec && !(wrAcc && adrIdx == dcp_pkg::IDX_ARM) && cfg[cntChan][dcp_pkg::CFG_REP_BIT]
    |=> chArmed[$past(cntChan)])
    else $error("repetitive channel disarmed itself");
  chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && !(acc && adrIdx == dcp_pkg::IDX_STAT) |=> (flags & $past(flags)) == $past(flags))
    else $error("done flag dropped without software");
  chk_stat_write_clear: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && wrAcc && adrIdx == dcp_pkg::IDX_STAT |=> (flags & ~$past(wb_dat_i[4:0] | doneVec)) == 5'h00)
    else $error("done flag survived a zero write");
  chk_stat_read_clear: assert property (@(posedge mclk) disable iff (!rstSync)
    ce && rdAcc && adrIdx == dcp_pkg::IDX_STAT |=> flags == $past(doneVec))
    else $error("status read did not clear the flags");
  cov_count_taken: cover property (@(posedge mclk) disable iff (!rstSync) ce && countValid);
  cov_stat_clear: cover property (@(posedge mclk) disable iff (!rstSync) ce && wrAcc && adrIdx == dcp_pkg::IDX_STAT);
  cov_abort: cover property (@(posedge mclk) disable iff (!rstSync) |chAbort);
  cov_auto_disarm: cover property (@(posedge mclk) disable iff (!rstSync) ce && |doneVec ##1 chArmed == 5'h00);
  cov_irq_rise: cover property (@(posedge mclk) disable iff (!rstSync) $rose(irq));
endmodule : dcp_arm_ctrl

// [sim/dcp_cpu_model.sv]
// CPU core model competing with the DMA for the shared memory bus
`timescale 1ns/1ns
module dcp_cpu_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic busy,
  output logic cpuReq
);
  // ----------------------------------------------------------------
  // Request level
  // ----------------------------------------------------------------
  // A stalled core keeps asking every cycle, so the request never drops on a loss
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuReq <= 1'b0;
    end else begin
      cpuReq <= busy;
    end
  end
endmodule : dcp_cpu_model

// [sim/tb.sv]
// Self-checking bench for the arm, abort, config and arbitration block
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [11:0] wbAdr = 12'h000;
  logic [31:0] wbDat = 32'h0, rdat, q;
  logic busy = 1'b0, cpuReq, dmaReq = 1'b0, cntDone = 1'b0, firstValid = 1'b0;
  logic [2:0] dmaChan = 3'h0, cntChan = 3'h0, firstChan = 3'h0;
  logic [7:0] firstByte = 8'h00, xferCount;
  logic cpuGnt, dmaGnt, countValid, irq;
  logic [4:0] chArmed, chAbort, lastAbort;
  int error_cnt = 0, total_checks = 0, cycCnt = 0, seed = 48794;
  int dG, cG, run, maxRun, r;
  logic [2:0] ch3, vl;
  logic m8, wd, ie, mk, rep;
  logic [7:0] b;

  always #5 mclk = ~mclk;

  dcp_cpu_model cpu (.mclk(mclk), .rst_n(rst_n), .busy(busy), .cpuReq(cpuReq));

  dcp_arm_ctrl DUT (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(rdat), .wb_ack_o(wbAck),
    .cpuReq(cpuReq), .dmaReq(dmaReq), .dmaChan(dmaChan), .cntDone(cntDone), .cntChan(cntChan),
    .firstValid(firstValid), .firstChan(firstChan), .firstByte(firstByte), .cpuGnt(cpuGnt),
    .dmaGnt(dmaGnt), .chArmed(chArmed), .chAbort(chAbort), .xferCount(xferCount),
    .countValid(countValid), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task final_report;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Hang guard well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycCnt++;
    if (cycCnt == 20000) begin
      error_cnt++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {idx, 2'b00};
    wbDat <= d;
    @(posedge mclk);
    // No assumed latency: only the global cycle ceiling ends this wait
    while (wbAck !== 1'b1) begin
      @(posedge mclk);
    end
    q = rdat;
    lastAbort = chAbort;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb

  task automatic pulse(input logic done, input logic [2:0] ch, input logic [7:0] v);
    @(posedge mclk);
    cntDone <= done;
    firstValid <= ~done;
    cntChan <= ch;
    firstChan <= ch;
    firstByte <= v;
    @(posedge mclk);
    cntDone <= 1'b0;
    firstValid <= 1'b0;
    @(posedge mclk);
  endtask : pulse

  task automatic arb(input logic [1:0] p, input logic [31:0] arm);
    wb(1'b1, dcp_pkg::IDX_CFG0, {30'h0, p});
    wb(1'b1, dcp_pkg::IDX_ARM, arm);
    @(posedge mclk);
    busy <= 1'b1;
    dmaReq <= 1'b1;
    dmaChan <= 3'h0;
    repeat (3) @(posedge mclk);
    dG = 0;
    cG = 0;
    run = 0;
    maxRun = 0;
    repeat (8) begin
      @(posedge mclk);
      if (dmaGnt === 1'b1) dG++;
      if (cpuGnt === 1'b1) begin
        cG++;
        run++;
        if (run > maxRun) maxRun = run;
      end else begin
        run = 0;
      end
    end
    busy <= 1'b0;
    dmaReq <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : arb

  function automatic logic [7:0] expCnt(input logic [7:0] v, input logic s7, input logic w);
    return (s7 && !w) ? {1'b0, v[6:0]} : v;
  endfunction : expCnt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(1'b0, dcp_pkg::IDX_ARM, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, dcp_pkg::IDX_STAT, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, dcp_pkg::IDX_MASK, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 10'h3FF, 32'hFFFFFFFF);
    wb(1'b0, 10'h3FF, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, dcp_pkg::IDX_ARM, 32'h1F);
    wb(1'b0, dcp_pkg::IDX_ARM, 32'h0);
    chk(q, 32'h1F);
    wb(1'b1, dcp_pkg::IDX_ARM, 32'h83);
    chk(lastAbort, 32'h03);
    wb(1'b0, dcp_pkg::IDX_ARM, 32'h0);
    chk(q, 32'h1C);
    wb(1'b1, dcp_pkg::IDX_ARM, 32'h0C);
    chk(lastAbort, 32'h0);
    wb(1'b0, dcp_pkg::IDX_ARM, 32'h0);
    chk(q, 32'h0C);
    arb(2'h0, 32'h1);
    chk(dG, 32'h0);
    arb(2'h1, 32'h1);
    chk(maxRun <= 1 && dG >= 3, 32'h1);
    arb(2'h2, 32'h1);
    chk(cG, 32'h0);
    arb(2'h2, 32'h0);
    chk(dG, 32'h0);
    for (int ch = 0; ch < 5; ch++) begin
      r = $random(seed);
      ie = r[0];
      mk = r[1];
      rep = r[2];
      wb(1'b1, dcp_pkg::IDX_CFG0 + 10'(ch), {23'h0, rep, 4'h0, ie, 3'h0});
      wb(1'b1, dcp_pkg::IDX_MASK, 32'(mk) << ch);
      wb(1'b1, dcp_pkg::IDX_ARM, 32'h1 << ch);
      pulse(1'b1, 3'(ch), 8'h00);
      chk(chArmed[ch], rep);
      chk(irq, ie & mk);
      wb(1'b0, dcp_pkg::IDX_STAT, 32'h0);
      chk(q, 32'h1 << ch);
      @(posedge mclk);
      chk(irq, 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      ch3 = 3'($unsigned(r) % 5);
      vl = (i < 2) ? 3'h1 : r[10:8];
      m8 = (i < 2) ? 1'b1 : r[11];
      wd = (i < 2) ? 1'(i) : r[12];
      b = (i < 2) ? 8'hFF : r[23:16];
      wb(1'b1, dcp_pkg::IDX_CFG0 + 10'(ch3), {23'h0, 1'b0, vl, wd, 1'b0, m8, 2'h0});
      wb(1'b1, dcp_pkg::IDX_ARM, 32'h1 << ch3);
      pulse(1'b0, ch3, b);
      chk(countValid, (vl != 3'h0 && vl != 3'h7));
      if (vl != 3'h0 && vl != 3'h7) chk(xferCount, expCnt(b, m8, wd));
    end
    // Clock enable low must swallow a done event; then zero-write clear keeps the others
    wb(1'b1, dcp_pkg::IDX_CFG0 + 10'h2, 32'h0);
    wb(1'b1, dcp_pkg::IDX_CFG0 + 10'h3, 32'h0);
    wb(1'b1, dcp_pkg::IDX_ARM, 32'h0C);
    ce <= 1'b0;
    pulse(1'b1, 3'h2, 8'h00);
    chk(chArmed, 32'h0C);
    ce <= 1'b1;
    pulse(1'b1, 3'h2, 8'h00);
    pulse(1'b1, 3'h3, 8'h00);
    chk(chArmed, 32'h0);
    wb(1'b1, dcp_pkg::IDX_STAT, 32'h1B);
    wb(1'b0, dcp_pkg::IDX_STAT, 32'h0);
    chk(q, 32'h08);
    final_report;
  end
endmodule : tb
